// [hw/lse_exec.sv]
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`default_nettype none
// How it works
// [RL1] load-lock reads the word at the operand address, like a plain load
// [RL2] address operand is register b, or the 8-bit immediate zero-extended
// [RL3] multi-word load fills consecutive registers from consecutive words
// [RL4] multi-word load moves count-remaining plus one words, sampled at start
// [RL5] count-remaining lives in channel control and its mirror register
// [RL6] software should not run multi-word load while freeze is set
// [RL7] load-and-set reads the word, then writes all ones to it
// [RL8] destination is written before the locked all-ones write
// [RL9] instruction bus-control field drives the memory access attributes
// [RL10] move-from-special copies the selected special register to a gpr
// [RL11] user access to a protected special register traps
// [RL12] trapped move-from-special leaves the destination gpr unchanged
// [RL13] move-to-special writes register b into the selected special register
// [RL14] trapped move-to-special leaves the special register unchanged
// [RL15] arithmetic flags change only when the alu status register is written
// [RL16] translation read is a no-op in supervisor mode, traps in user mode
// [RL17] opcode bits 31:24, first field 15:8, second 7:0, low opcode bit imm
module lse_exec #(
   parameter int NGPR = 16,
   parameter int NSPR = 8
) (
   input  wire  logic        hclk,
   input  wire  logic        hresetn,
   input  wire  logic        hsel,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic [31:0] hwdata,
   input  wire  logic        hready,
   output logic              hreadyout,
   output logic [31:0]       hrdata,
   output logic              hresp,
   output logic              irq,
   output logic              mem_req,
   output logic              mem_write,
   output logic              mem_lock,
   output logic [31:0]       mem_addr,
   output logic [31:0]       mem_wdata,
   output logic [6:0]        mem_cntl,
   input  wire  logic        mem_ack,
   input  wire  logic [31:0] mem_rdata
);
   localparam int GW = $clog2(NGPR);
   localparam int SW = $clog2(NSPR);

   typedef struct packed {
      lse_pkg::lse_fsm_e          fsm;
      logic [NGPR-1:0][31:0]      gpr;
      logic [NSPR-1:0][31:0]      spr;
      logic [31:0]                instr;
      logic [1:0]                 ctrl;
      logic [31:0]                chan_ctrl;
      logic [lse_pkg::EV_W-1:0]   ev_stat;
      logic [lse_pkg::EV_W-1:0]   ev_mask;
      logic [7:0]                 gpr_sel;
      logic [7:0]                 spr_sel;
      logic [7:0]                 dst;
      logic [lse_pkg::CR_W-1:0]   cnt;
      logic                       is_set;
      logic                       last_trap;
      logic [7:0]                 haddr_l;
      logic                       wr_pend;
      logic                       rd_pend;
      logic                       hreadyout;
      logic [31:0]                hrdata;
      logic                       hresp;
      logic                       irq;
      logic                       mem_req;
      logic                       mem_write;
      logic                       mem_lock;
      logic [31:0]                mem_addr;
      logic [31:0]                mem_wdata;
      logic [6:0]                 mem_cntl;
   } lse_state_s;

   lse_state_s s_r;
   lse_state_s s_nxt;

   // general register index from an 8-bit field
   function automatic logic [GW-1:0] gidx(input logic [7:0] f);
      gidx = f[GW-1:0];
   endfunction : gidx

   // special register index from a select code
   function automatic logic [SW-1:0] sidx(input logic [7:0] f);
      sidx = f[SW-1:0];
   endfunction : sidx

   // protected special register seen from user mode
   function automatic logic prot_hit(input logic [7:0] sa,
                                     input logic       super_mode);
      prot_hit = !super_mode && (sa < lse_pkg::SPR_PROT_LIMIT);
   endfunction : prot_hit

   // register read mux
   function automatic logic [31:0] rd_mux(input lse_state_s s);
      rd_mux = 32'h00000000;
      unique case (s.haddr_l)
         lse_pkg::OFS_CTRL:      rd_mux = {30'h00000000, s.ctrl};
         lse_pkg::OFS_INSTR:     rd_mux = s.instr;
         lse_pkg::OFS_STATUS:
            rd_mux = {30'h00000000, s.last_trap,
                      s.fsm != lse_pkg::LSE_IDLE};
         lse_pkg::OFS_IRQ_STAT:  rd_mux = {28'h0000000, s.ev_stat};
         lse_pkg::OFS_IRQ_MASK:  rd_mux = {28'h0000000, s.ev_mask};
         lse_pkg::OFS_CHAN_CTRL: rd_mux = s.chan_ctrl;
         lse_pkg::OFS_COUNT_REM:
            rd_mux = {24'h000000,
                      s.chan_ctrl[lse_pkg::CR_LSB +: lse_pkg::CR_W]};
         lse_pkg::OFS_GPR_SEL:   rd_mux = {24'h000000, s.gpr_sel};
         lse_pkg::OFS_GPR_DATA:  rd_mux = s.gpr[gidx(s.gpr_sel)];
         lse_pkg::OFS_SPR_SEL:   rd_mux = {24'h000000, s.spr_sel};
         lse_pkg::OFS_SPR_DATA:  rd_mux = s.spr[sidx(s.spr_sel)];
         default:                rd_mux = 32'h00000000;
      endcase
   endfunction : rd_mux

   logic                    acc;
   logic [7:0]              op;
   logic [7:0]              fa;
   logic [7:0]              fb;
   logic [7:0]              fc;
   logic [31:0]             second_source_operand;
   logic [lse_pkg::EV_W-1:0] ev_set;

   always_comb
   begin
      s_nxt  = s_r;
      ev_set = '0;
      acc    = hsel && htrans[1] && hready;
      // [RL17] field split
      op = s_r.instr[lse_pkg::OP_LSB +: 8];
      fa = s_r.instr[lse_pkg::RA_LSB +: 8];
      fb = s_r.instr[lse_pkg::RB_LSB +: 8];
      fc = s_r.instr[lse_pkg::RC_LSB +: 8];
      // [RL2] operand select
      second_source_operand = op[0] ? {24'h000000, fb} : s_r.gpr[gidx(fb)];

      // register write data phase
      if (s_r.wr_pend)
      begin
         unique case (s_r.haddr_l)
            lse_pkg::OFS_CTRL:
               s_nxt.ctrl = hwdata[1:0];
            lse_pkg::OFS_INSTR:
               if (s_r.fsm == lse_pkg::LSE_IDLE)
               begin
                  s_nxt.instr = hwdata;
                  s_nxt.fsm   = lse_pkg::LSE_DEC;
               end
               else
               begin
                  ev_set[lse_pkg::EV_REFUSED] = 1'b1;
               end
            lse_pkg::OFS_IRQ_STAT:
               s_nxt.ev_stat = s_r.ev_stat & ~hwdata[lse_pkg::EV_W-1:0];
            lse_pkg::OFS_IRQ_MASK:
               s_nxt.ev_mask = hwdata[lse_pkg::EV_W-1:0];
            // [RL5] one field, two views
            lse_pkg::OFS_CHAN_CTRL:
               s_nxt.chan_ctrl = hwdata;
            lse_pkg::OFS_COUNT_REM:
               s_nxt.chan_ctrl[lse_pkg::CR_LSB +: lse_pkg::CR_W] =
                  hwdata[lse_pkg::CR_W-1:0];
            lse_pkg::OFS_GPR_SEL:
               s_nxt.gpr_sel = hwdata[7:0];
            lse_pkg::OFS_GPR_DATA:
               s_nxt.gpr[gidx(s_r.gpr_sel)] = hwdata;
            lse_pkg::OFS_SPR_SEL:
               s_nxt.spr_sel = hwdata[7:0];
            lse_pkg::OFS_SPR_DATA:
               s_nxt.spr[sidx(s_r.spr_sel)] = hwdata;
            default:
               s_nxt.ctrl = s_r.ctrl;
         endcase
      end

      // read data phase: one wait state, data from a flop
      if (s_r.rd_pend)
      begin
         s_nxt.hrdata    = rd_mux(s_r);
         s_nxt.hreadyout = 1'b1;
         s_nxt.rd_pend   = 1'b0;
      end

      // address phase
      s_nxt.wr_pend = 1'b0;
      if (acc)
      begin
         s_nxt.haddr_l   = haddr[7:0];
         s_nxt.wr_pend   = hwrite;
         s_nxt.rd_pend   = !hwrite;
         s_nxt.hreadyout = hwrite;
      end

      // instruction execution
      unique case (s_r.fsm)
         lse_pkg::LSE_IDLE:
            s_nxt.mem_req = 1'b0;
         lse_pkg::LSE_DEC:
         begin
            s_nxt.fsm       = lse_pkg::LSE_IDLE;
            s_nxt.last_trap = 1'b0;
            if (op[7:1] == lse_pkg::OPH_LOAD_LOCK ||
                op[7:1] == lse_pkg::OPH_LOAD_SET ||
                op[7:1] == lse_pkg::OPH_LOAD_MULT)
            begin
               // [RL1] plain read, locked only for load-and-set
               s_nxt.mem_req   = 1'b1;
               s_nxt.mem_write = 1'b0;
               s_nxt.mem_addr  = second_source_operand;
               // [RL9] bus attributes
               s_nxt.mem_cntl  = s_r.instr[lse_pkg::CNTL_LSB +:
                                            lse_pkg::CNTL_W];
               s_nxt.is_set    = op[7:1] == lse_pkg::OPH_LOAD_SET;
               // [RL8] lock over read and write
               s_nxt.mem_lock  = op[7:1] == lse_pkg::OPH_LOAD_SET;
               s_nxt.dst       = fa;
               // [RL4] count sampled at start
               s_nxt.cnt = (op[7:1] == lse_pkg::OPH_LOAD_MULT) ?
                  s_r.chan_ctrl[lse_pkg::CR_LSB +: lse_pkg::CR_W] : '0;
               s_nxt.fsm       = lse_pkg::LSE_RD;
            end
            else if (op == lse_pkg::OP_MOVE_FROM)
            begin
               // [RL11] protection check
               if (prot_hit(fa, s_r.ctrl[lse_pkg::CTRL_SUPER_BIT]))
               begin
                  // [RL12] destination untouched
                  s_nxt.last_trap          = 1'b1;
                  ev_set[lse_pkg::EV_TRAP] = 1'b1;
               end
               else
               begin
                  // [RL10] special to general
                  s_nxt.gpr[gidx(fc)]      = s_r.spr[sidx(fa)];
                  ev_set[lse_pkg::EV_DONE] = 1'b1;
               end
            end
            else if (op == lse_pkg::OP_MOVE_TO)
            begin
               // [RL11] protection check
               if (prot_hit(fa, s_r.ctrl[lse_pkg::CTRL_SUPER_BIT]))
               begin
                  // [RL14] special register kept
                  s_nxt.last_trap          = 1'b1;
                  ev_set[lse_pkg::EV_TRAP] = 1'b1;
               end
               else
               begin
                  // [RL13] general to special
                  // [RL15] flags only via status select
                  s_nxt.spr[sidx(fa)]      = s_r.gpr[gidx(fb)];
                  ev_set[lse_pkg::EV_DONE] = 1'b1;
               end
            end
            else if (op == lse_pkg::OP_XLAT_READ)
            begin
               // [RL16] privileged no-op
               if (!s_r.ctrl[lse_pkg::CTRL_SUPER_BIT])
               begin
                  s_nxt.last_trap          = 1'b1;
                  ev_set[lse_pkg::EV_TRAP] = 1'b1;
               end
               else
               begin
                  ev_set[lse_pkg::EV_DONE] = 1'b1;
               end
            end
            else
            begin
               ev_set[lse_pkg::EV_ILLEGAL] = 1'b1;
            end
         end
         lse_pkg::LSE_RD:
            if (mem_ack)
            begin
               s_nxt.gpr[gidx(s_r.dst)] = mem_rdata;
               if (s_r.is_set)
               begin
                  // [RL7] all-ones write follows the read
                  // [RL8] destination already written
                  s_nxt.mem_write = 1'b1;
                  s_nxt.mem_wdata = lse_pkg::ALL_ONES;
                  s_nxt.fsm       = lse_pkg::LSE_WR;
               end
               else if (s_r.cnt != '0)
               begin
                  // [RL3] next word, next register
                  s_nxt.cnt      = s_r.cnt - 1'b1;
                  s_nxt.mem_addr = s_r.mem_addr + lse_pkg::WORD_STEP;
                  s_nxt.dst      = s_r.dst + 8'h01;
               end
               else
               begin
                  s_nxt.mem_req            = 1'b0;
                  s_nxt.fsm                = lse_pkg::LSE_IDLE;
                  ev_set[lse_pkg::EV_DONE] = 1'b1;
               end
            end
         lse_pkg::LSE_WR:
            if (mem_ack)
            begin
               s_nxt.mem_req            = 1'b0;
               s_nxt.mem_write          = 1'b0;
               s_nxt.mem_lock           = 1'b0;
               s_nxt.fsm                = lse_pkg::LSE_IDLE;
               ev_set[lse_pkg::EV_DONE] = 1'b1;
            end
         default:
            s_nxt.fsm = lse_pkg::LSE_IDLE;
      endcase

      // sticky events, set wins over clear
      s_nxt.ev_stat = s_nxt.ev_stat | ev_set;
      s_nxt.irq     = |(s_nxt.ev_stat & s_nxt.ev_mask);
      s_nxt.hresp   = 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_r           <= '0;
         s_r.fsm       <= lse_pkg::LSE_IDLE;
         s_r.ctrl      <= lse_pkg::CTRL_RESET;
         s_r.ev_mask   <= lse_pkg::IRQ_MASK_RESET;
         s_r.hreadyout <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign hreadyout = s_r.hreadyout;
   assign hrdata    = s_r.hrdata;
   assign hresp     = s_r.hresp;
   assign irq       = s_r.irq;
   assign mem_req   = s_r.mem_req;
   assign mem_write = s_r.mem_write;
   assign mem_lock  = s_r.mem_lock;
   assign mem_addr  = s_r.mem_addr;
   assign mem_wdata = s_r.mem_wdata;
   assign mem_cntl  = s_r.mem_cntl;

   logic unused_ok;
   assign unused_ok = &{1'b0, hsize, haddr[31:8], htrans[0]};

endmodule : lse_exec
`default_nettype wire

// [hw/lse_pkg.sv]
`default_nettype none
package lse_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_INSTR     = 8'h04;
   localparam logic [7:0] OFS_STATUS    = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;
   localparam logic [7:0] OFS_CHAN_CTRL = 8'h14;
   localparam logic [7:0] OFS_COUNT_REM = 8'h18;
   localparam logic [7:0] OFS_GPR_SEL   = 8'h1C;
   localparam logic [7:0] OFS_GPR_DATA  = 8'h20;
   localparam logic [7:0] OFS_SPR_SEL   = 8'h24;
   localparam logic [7:0] OFS_SPR_DATA  = 8'h28;
   // control register fields
   localparam int         CTRL_SUPER_BIT  = 0;
   localparam int         CTRL_FREEZE_BIT = 1;
   localparam logic [1:0] CTRL_RESET      = 2'h1;
   // channel control: count remaining field position
   localparam int         CR_LSB = 16;
   localparam int         CR_W   = 8;
   // interrupt status bits
   localparam int         EV_DONE    = 0;
   localparam int         EV_TRAP    = 1;
   localparam int         EV_ILLEGAL = 2;
   localparam int         EV_REFUSED = 3;
   localparam int         EV_W       = 4;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
   // instruction fields
   localparam int OP_LSB   = 24;
   localparam int CNTL_LSB = 16;
   localparam int CNTL_W   = 7;
   localparam int RC_LSB   = 16;
   localparam int RA_LSB   = 8;
   localparam int RB_LSB   = 0;
   // opcodes; for the loads the low bit selects the immediate
   localparam logic [6:0] OPH_LOAD_LOCK = 7'h03;
   localparam logic [6:0] OPH_LOAD_SET  = 7'h13;
   localparam logic [6:0] OPH_LOAD_MULT = 7'h1B;
   localparam logic [7:0] OP_MOVE_FROM  = 8'hC6;
   localparam logic [7:0] OP_MOVE_TO    = 8'hCE;
   localparam logic [7:0] OP_XLAT_READ  = 8'hB6;
   // special registers below this select code are protected
   localparam logic [7:0] SPR_PROT_LIMIT = 8'h80;
   localparam logic [7:0] SPR_ALU_STATUS = 8'h85;
   localparam logic [31:0] ALL_ONES      = 32'hFFFFFFFF;
   localparam logic [31:0] WORD_STEP     = 32'h00000004;
   typedef enum logic [3:0] {
      LSE_IDLE = 4'h1,
      LSE_DEC  = 4'h2,
      LSE_RD   = 4'h4,
      LSE_WR   = 4'h8
   } lse_fsm_e;
endpackage : lse_pkg
`default_nettype wire

// [sim/lse_exec_bench.sv]
`default_nettype none
module lse_exec_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize  = 3'h2;
   logic [31:0] haddr  = 32'h0, hwdata = 32'h0, v;
   logic [31:0] hrdata, mem_addr, mem_wdata, mem_rdata;
   logic        hreadyout, hresp, irq, mem_req, mem_write, mem_lock, mem_ack;
   logic [6:0]  mem_cntl;
   int          miscompares = 0, total_checks = 0, i, n;

   always #10 hclk = ~hclk;

   lse_exec lse_exec_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .irq,
      .mem_req, .mem_write, .mem_lock, .mem_addr, .mem_wdata, .mem_cntl,
      .mem_ack, .mem_rdata);
   lse_mem_model lse_mem_model_inst (.hclk, .hresetn, .mem_req, .mem_write,
      .mem_addr, .mem_wdata, .mem_cntl, .mem_ack, .mem_rdata);

   task stop_test();
      if (miscompares == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test

   task timed_out();
      miscompares++;
      stop_test();
   endtask : timed_out

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task edge_wait();
      int k;
      k = 0;
      do
         @(posedge hclk);
      while (hreadyout !== 1'b1 && ++k < 50);
      if (k >= 50)
         timed_out();
   endtask : edge_wait

   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h0, a};
      edge_wait();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      edge_wait();
      v = hrdata;
   endtask : xfer

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
   endtask : rd

   task run(input logic [31:0] ins);
      int k;
      k = 0;
      wr(lse_pkg::OFS_INSTR, ins);
      do
         rd(lse_pkg::OFS_STATUS);
      while (v[0] !== 1'b0 && ++k < 40);
      if (k >= 40)
         timed_out();
   endtask : run

   task getg(input logic [7:0] r);
      wr(lse_pkg::OFS_GPR_SEL, {24'h0, r});
      rd(lse_pkg::OFS_GPR_DATA);
   endtask : getg

   task setg(input logic [7:0] r, input logic [31:0] d);
      wr(lse_pkg::OFS_GPR_SEL, {24'h0, r});
      wr(lse_pkg::OFS_GPR_DATA, d);
   endtask : setg

   task getspr(input logic [7:0] s);
      wr(lse_pkg::OFS_SPR_SEL, {24'h0, s});
      rd(lse_pkg::OFS_SPR_DATA);
   endtask : getspr

   function automatic logic [31:0] ld(input logic [6:0] oph, input logic im,
      input logic [6:0] cn, input logic [7:0] ra, input logic [7:0] rb);
      return {oph, im, 1'b0, cn, ra, rb};
   endfunction : ld

   initial
   begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      rd(lse_pkg::OFS_CTRL);
      chk("ctrl", v, {30'h0, lse_pkg::CTRL_RESET});
      rd(lse_pkg::OFS_IRQ_MASK);
      chk("mask", v, 32'h0);
      wr(8'h40, 32'hFFFFFFFF);
      rd(8'h40);
      chk("unmapped", v, 32'h0);
      lse_mem_model_inst.mem[16] = 32'h12345678;
      lse_mem_model_inst.mem[9]  = 32'hA5A50F0F;
      lse_mem_model_inst.mem[12] = 32'h000000C3;
      for (i = 0; i < 4; i++)
         lse_mem_model_inst.mem[20 + i] = 32'h10000000 + i;
      setg(8'h02, 32'h40);
      run(ld(lse_pkg::OPH_LOAD_LOCK, 1'b0, 7'h2A, 8'h03, 8'h02));
      getg(8'h03);
      chk("lock_load", v, 32'h12345678);
      chk("cntl", lse_mem_model_inst.last_cntl, 32'h2A);
      run(ld(lse_pkg::OPH_LOAD_LOCK, 1'b1, 7'h11, 8'h04, 8'h24));
      getg(8'h04);
      chk("imm_load", v, 32'hA5A50F0F);
      setg(8'h08, 32'hDEADBEEF);
      wr(lse_pkg::OFS_COUNT_REM, 32'h2);
      rd(lse_pkg::OFS_CHAN_CTRL);
      chk("chan_ctrl", v, 32'h00020000);
      n = lse_mem_model_inst.rd_count;
      run(ld(lse_pkg::OPH_LOAD_MULT, 1'b1, 7'h00, 8'h05, 8'h50));
      chk("words", lse_mem_model_inst.rd_count - n, 32'h3);
      for (i = 0; i < 4; i++)
      begin
         getg(8'(5 + i));
         chk("mult", v, i < 3 ? 32'h10000000 + i : 32'hDEADBEEF);
      end
      run(ld(lse_pkg::OPH_LOAD_SET, 1'b1, 7'h05, 8'h09, 8'h30));
      getg(8'h09);
      chk("set_general_destination", v, 32'h000000C3);
      chk("set_mem", lse_mem_model_inst.mem[12], lse_pkg::ALL_ONES);
      wr(lse_pkg::OFS_IRQ_STAT, 32'hF);
      wr(lse_pkg::OFS_IRQ_MASK, 32'h2);
      setg(8'h01, 32'hF0);
      run({lse_pkg::OP_MOVE_TO, 8'h00, lse_pkg::SPR_ALU_STATUS, 8'h01});
      run({lse_pkg::OP_MOVE_TO, 16'h0003, 8'h01});
      getspr(lse_pkg::SPR_ALU_STATUS);
      chk("spr_write", v, 32'hF0);
      run({lse_pkg::OP_MOVE_FROM, 16'h0A03, 8'h00});
      getg(8'h0A);
      chk("spr_read", v, 32'hF0);
      run({lse_pkg::OP_XLAT_READ, 24'h0});
      rd(lse_pkg::OFS_IRQ_STAT);
      chk("xlat_super", v, 32'h1);
      chk("irq_masked", irq, 32'h0);
      // user mode, freeze left clear
      wr(lse_pkg::OFS_CTRL, 32'h0);
      setg(8'h01, 32'h55);
      setg(8'h0B, 32'h77);
      run({lse_pkg::OP_MOVE_TO, 16'h0003, 8'h01});
      chk("trap_irq", irq, 32'h1);
      getspr(8'h03);
      chk("spr_kept", v, 32'hF0);
      wr(lse_pkg::OFS_IRQ_STAT, 32'hF);
      rd(lse_pkg::OFS_IRQ_STAT);
      chk("irq_clear", irq, 32'h0);
      run({lse_pkg::OP_MOVE_FROM, 16'h0B03, 8'h00});
      getg(8'h0B);
      chk("gpr_kept", v, 32'h77);
      run({lse_pkg::OP_MOVE_TO, 8'h00, lse_pkg::SPR_ALU_STATUS, 8'h01});
      getspr(lse_pkg::SPR_ALU_STATUS);
      chk("user_spr", v, 32'h55);
      run({lse_pkg::OP_MOVE_TO, 16'h0086, 8'h0B});
      getspr(lse_pkg::SPR_ALU_STATUS);
      chk("flags_kept", v, 32'h55);
      getspr(8'h86);
      chk("spr_other", v, 32'h77);
      run({lse_pkg::OP_XLAT_READ, 24'h0});
      rd(lse_pkg::OFS_STATUS);
      chk("xlat_user", v, 32'h2);
      wr(lse_pkg::OFS_IRQ_STAT, 32'hF);
      run(32'h00000000);
      rd(lse_pkg::OFS_IRQ_STAT);
      chk("illegal", v, 32'h4);
      wr(lse_pkg::OFS_IRQ_STAT, 32'hF);
      wr(lse_pkg::OFS_INSTR,
         ld(lse_pkg::OPH_LOAD_LOCK, 1'b1, 7'h00, 8'h0C, 8'h40));
      run({lse_pkg::OP_XLAT_READ, 24'h0});
      rd(lse_pkg::OFS_IRQ_STAT);
      chk("refused", v, 32'h9);
      getg(8'h0C);
      chk("busy_load", v, 32'h12345678);
      stop_test();
   end
endmodule : lse_exec_bench
`default_nettype wire

// [sim/lse_exec_checker.sv]
`default_nettype none
module lse_exec_checker (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        mem_req,
   input wire logic        mem_write,
   input wire logic        mem_lock,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [6:0]  mem_cntl,
   input wire logic        mem_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic ahb_go;
   logic rd_done;
   assign ahb_go  = hsel && htrans[1] && hready;
   assign rd_done = mem_req && mem_ack && !mem_write;

   okay_resp_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   read_wait_a: assert property (
      ahb_go && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not one wait state");
   write_nowait_a: assert property (ahb_go && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   req_hold_a: assert property (
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
         && $stable(mem_write) && $stable(mem_cntl))
      else $error("memory request changed before ack");
   ones_write_a: assert property (
      mem_req && mem_write |-> mem_wdata == lse_pkg::ALL_ONES && mem_lock)
      else $error("write access not locked all ones");
   set_order_a: assert property (
      rd_done && mem_lock |=> mem_req && mem_write && mem_lock
         && $stable(mem_addr))
      else $error("locked read not followed by write");
   set_release_a: assert property (
      mem_req && mem_write && mem_ack |=> !mem_req && !mem_lock)
      else $error("lock held after set write");
   word_step_a: assert property (
      rd_done && !mem_lock ##1 mem_req
         |-> mem_addr == $past(mem_addr) + lse_pkg::WORD_STEP)
      else $error("multi load address step wrong");

   cover property (rd_done && mem_lock);
   cover property (rd_done ##1 mem_req && !mem_write);
   cover property (ahb_go && !hwrite);
endmodule : lse_exec_checker

bind lse_exec lse_exec_checker lse_exec_checker_inst (.hclk, .hresetn,
   .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .mem_req,
   .mem_write, .mem_lock, .mem_addr, .mem_wdata, .mem_cntl, .mem_ack);
`default_nettype wire

// [sim/lse_mem_model.sv]
`default_nettype none
module lse_mem_model (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        mem_req,
   input wire logic        mem_write,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [6:0]  mem_cntl,
   output logic            mem_ack,
   output logic [31:0]     mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [64];
   logic [31:0] rd_r      = 32'h0;
   logic [6:0]  last_cntl = 7'h0;
   int          wait_n    = 0;
   int          pace      = 0;
   int          rd_count  = 0;
   // data line shows garbage outside the ack cycle
   assign mem_rdata = mem_ack ? rd_r : ~rd_r;
   // answers after 0, 1 or 2 idle cycles in turn
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mem_ack <= 1'b0;
         wait_n  <= 0;
      end
      else if (mem_ack)
         mem_ack <= 1'b0;
      else if (mem_req && wait_n < pace % 3)
         wait_n <= wait_n + 1;
      else if (mem_req)
      begin
         mem_ack   <= 1'b1;
         wait_n    <= 0;
         pace      <= pace + 1;
         last_cntl <= mem_cntl;
         rd_r      <= mem[mem_addr[7:2]];
         if (mem_write)
            mem[mem_addr[7:2]] <= mem_wdata;
         else
            rd_count <= rd_count + 1;
      end
   end
endmodule : lse_mem_model
`default_nettype wire
